// ==== pkg/twc_pkg.sv ====
package twc_pkg;

    // ------------------------------------------------------------
    // command framing
    // ------------------------------------------------------------
    localparam int          CMD_W          = 16;
    localparam int          HIST_W         = 48;
    localparam int          BITCNT_W       = 4;
    localparam logic [3:0]  BITCNT_LAST    = 4'h f;
    localparam logic [15:0] PORT_RST_CODE  = 16'h8d00;
    localparam logic [15:0] PORT_REL_CODE  = 16'h8d02;
    localparam logic [15:0] CORE_RST_CODE  = 16'hbd01;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS  = 5;
    localparam int          MS_NS          = 1000000;
    localparam int          MS_CYC_DEF     = MS_NS / CLK_PERIOD_NS;
    localparam int          CAL_TIME_US    = 500;
    localparam int          CAL_CYC_DEF    = (CAL_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int          PRE_W          = 18;
    localparam int          CAL_W          = 17;
    localparam int          MS_W           = 7;
    localparam int          STOP_SEL_W     = 4;
    localparam int          STOP_COARSE_B  = 3;
    localparam logic [6:0]  STOP_FINE_BASE = 7'h02;
    localparam logic [6:0]  STOP_COARSE_MS = 7'h0a;

    // ------------------------------------------------------------
    // synchroniser lanes
    // ------------------------------------------------------------
    localparam int          SY_W           = 3;
    localparam int          SY_DATA        = 0;
    localparam int          SY_PEN         = 1;
    localparam int          SY_CRST        = 2;

    typedef enum logic [1:0]
    {
        ST_SLEEP = 2'b00,
        ST_TX    = 2'b01,
        ST_CAL   = 2'b10
    } twc_state_t;

    // stop window in ms: 2..9 fine steps, 20..90 coarse steps
    function automatic logic [6:0] twc_stop_ms(input logic [3:0] sel);
        logic [6:0] b;
        b = {4'h0, sel[2:0]} + STOP_FINE_BASE;
        return sel[STOP_COARSE_B] ? 7'(b * STOP_COARSE_MS) : b;
    endfunction

endpackage

// ==== pkg/twc_evt_if.sv ====
`timescale 1ns/1ps
interface twc_evt_if;
    logic port_en;
    logic crst_tgl;

    modport link
    (
        output port_en,
        output crst_tgl
    );

    modport core
    (
        input  port_en,
        input  crst_tgl
    );
endinterface

// ==== core/twc_sync.sv ====
`timescale 1ns/1ps
module twc_sync
    import twc_pkg::*;
#(
    parameter int W = 1
)
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // async in, filtered out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed
    {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } twc_sync_st_t;

    twc_sync_st_t s_r;
    twc_sync_st_t s_nxt;

    always_comb
    begin
        s_nxt    = s_r;
        s_nxt.s1 = d;
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
        // a change counts only once two later stages agree
        for (int i = 0; i < W; i++)
        begin
            if (s_r.s2[i] == s_r.s3[i])
            begin
                s_nxt.q[i] = s_r.s3[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.q;

    agree_take_a: assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.s2 == s_r.s3) |=> (s_r.q == $past(s_r.s3)))
        else $error("filtered output missed an agreed value");

endmodule

// ==== core/twc_link_rx.sv ====
`timescale 1ns/1ps
module twc_link_rx
    import twc_pkg::*;
(
    // link clock and reset
    input  wire logic port_clk,
    input  wire logic rst_n,
    // command data line
    input  wire logic port_data,
    // events towards the core
    twc_evt_if.link   evt
);

    typedef struct packed
    {
        logic [HIST_W-1:0]   hist;
        logic [BITCNT_W-1:0] cnt;
        logic                port_en;
        logic                crst_tgl;
    } twc_link_st_t;

    twc_link_st_t s_r;
    twc_link_st_t s_nxt;
    logic         prst_hit;
    logic         frame_end;

    always_comb
    begin
        s_nxt      = s_r;
        s_nxt.hist = {s_r.hist[HIST_W-2:0], port_data};
        prst_hit   = (s_nxt.hist[HIST_W-1:CMD_W] == '0)
                   && (s_nxt.hist[CMD_W-1:0] == PORT_RST_CODE);
        frame_end  = s_r.port_en && (s_r.cnt == BITCNT_LAST);
        // the long reset pattern is recognised in any state
        if (prst_hit)
        begin
            s_nxt.port_en = 1'b1;
            s_nxt.cnt     = '0;
        end
        else if (frame_end)
        begin
            s_nxt.cnt = '0;
            if (s_nxt.hist[CMD_W-1:0] == PORT_REL_CODE)
            begin
                s_nxt.port_en = 1'b0;
            end
            else if (s_nxt.hist[CMD_W-1:0] == CORE_RST_CODE)
            begin
                s_nxt.crst_tgl = ~s_r.crst_tgl;
            end
            // any other code falls through untouched
        end
        else if (s_r.port_en)
        begin
            s_nxt.cnt = BITCNT_W'(s_r.cnt + 1'b1);
        end
    end

    // the link clock only runs during commands, so all state moves on
    // its falling edges and nothing here waits for a later edge
    always_ff @(negedge port_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign evt.port_en  = s_r.port_en;
    assign evt.crst_tgl = s_r.crst_tgl;

    prst_open_a: assert property (@(negedge port_clk) disable iff (!rst_n)
        prst_hit |=> (s_r.port_en && s_r.cnt == '0))
        else $error("port reset did not open the port");
    rel_close_a: assert property (@(negedge port_clk) disable iff (!rst_n)
        (!prst_hit && frame_end && s_nxt.hist[CMD_W-1:0] == PORT_REL_CODE)
        |=> !s_r.port_en)
        else $error("release command did not close the port");
    crst_flip_a: assert property (@(negedge port_clk) disable iff (!rst_n)
        (!prst_hit && frame_end && s_nxt.hist[CMD_W-1:0] == CORE_RST_CODE)
        |=> (s_r.crst_tgl != $past(s_r.crst_tgl)))
        else $error("core reset command not forwarded");
    idle_quiet_a: assert property (@(negedge port_clk) disable iff (!rst_n)
        !frame_end |=> $stable(s_r.crst_tgl))
        else $error("core reset raised outside a frame end");
    cnt_run_a: assert property (@(negedge port_clk) disable iff (!rst_n)
        (s_r.port_en && !prst_hit && !frame_end)
        |=> (s_r.cnt == BITCNT_W'($past(s_r.cnt) + 1'b1)))
        else $error("bit counter skipped a falling edge");
    rel_seen_c: cover property (@(negedge port_clk) disable iff (!rst_n)
        $fell(s_r.port_en));

endmodule

// ==== core/twc_cmd_ctrl.sv ====
`timescale 1ns/1ps
module twc_cmd_ctrl
    import twc_pkg::*;
#(
    parameter int MS_CYCLES  = MS_CYC_DEF,
    parameter int CAL_CYCLES = CAL_CYC_DEF
)
(
    // core clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    // two-wire command port
    input  wire logic                  port_clk,
    input  wire logic                  port_data,
    // configuration
    input  wire logic                  trigger_edge_select,
    input  wire logic [STOP_SEL_W-1:0] stop_sel,
    // status and control towards the transmitter
    output logic                       tx_active,
    output logic                       tx_data,
    output logic                       cal_busy,
    output logic                       sleep_state,
    output logic                       port_enabled,
    output logic                       core_reset
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rsync_r;
    logic       rst_core_n;

    // kept outside the state struct: it must see the raw reset
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rsync_r <= 2'b00;
        end
        else
        begin
            rsync_r <= {rsync_r[0], 1'b1};
        end
    end

    assign rst_core_n = rsync_r[1];

    // ------------------------------------------------------------
    // link side and crossing
    // ------------------------------------------------------------
    twc_evt_if evt ();

    // the port keeps its own state across a core reset, so it is
    // cleared only by the device reset and never by the command
    twc_link_rx u_link
    (
        .port_clk  (port_clk),
        .rst_n     (rst_core_n),
        .port_data (port_data),
        .evt       (evt.link)
    );

    logic [SY_W-1:0] sy_in;
    logic [SY_W-1:0] sy_q;

    assign sy_in[SY_DATA] = port_data;
    assign sy_in[SY_PEN]  = evt.port_en;
    assign sy_in[SY_CRST] = evt.crst_tgl;

    twc_sync #(.W(SY_W)) u_sync
    (
        .clk   (core_clk),
        .rst_n (rst_core_n),
        .d     (sy_in),
        .q     (sy_q)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed
    {
        twc_state_t        state;
        logic              data_last;
        logic              crst_seen;
        logic [PRE_W-1:0]  pre;
        logic [MS_W-1:0]   ms;
        logic [CAL_W-1:0]  cal;
        logic              tx_active;
        logic              tx_data;
        logic              cal_busy;
        logic              sleep_state;
        logic              port_en;
        logic              core_reset;
    } twc_core_st_t;

    localparam twc_core_st_t CORE_RST_VAL = '{
        state       : ST_SLEEP,
        sleep_state : 1'b1,
        default     : '0
    };

    twc_core_st_t s_r;
    twc_core_st_t s_nxt;

    logic            data_f;
    logic            pen_f;
    logic            crst_ev;
    logic            rise;
    logic            fall;
    logic            trig;
    logic [MS_W-1:0] win;
    logic            ms_tick;
    logic [MS_W-1:0] ms_inc;

    assign data_f  = sy_q[SY_DATA];
    assign pen_f   = sy_q[SY_PEN];
    assign crst_ev = sy_q[SY_CRST] ^ s_r.crst_seen;
    assign rise    = data_f & ~s_r.data_last;
    assign fall    = ~data_f & s_r.data_last;
    assign trig    = trigger_edge_select ? rise : fall;
    assign win     = twc_stop_ms(stop_sel);
    assign ms_tick = (s_r.pre == PRE_W'(MS_CYCLES - 1));
    assign ms_inc  = MS_W'(s_r.ms + 1'b1);

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_comb
    begin
        s_nxt            = s_r;
        s_nxt.data_last  = data_f;
        s_nxt.crst_seen  = sy_q[SY_CRST];
        s_nxt.port_en    = pen_f;
        s_nxt.core_reset = 1'b0;
        // a core reset beats any other event in the same cycle
        if (crst_ev)
        begin
            s_nxt.state      = ST_CAL;
            s_nxt.core_reset = 1'b1;
            s_nxt.pre        = '0;
            s_nxt.ms         = '0;
            s_nxt.cal        = '0;
        end
        else
        begin
            case (s_r.state)
                ST_SLEEP:
                begin
                    s_nxt.pre = '0;
                    s_nxt.ms  = '0;
                    // edges only start a run once the port is released
                    if (!pen_f && trig)
                    begin
                        s_nxt.state = ST_TX;
                    end
                end
                ST_TX:
                begin
                    if (data_f)
                    begin
                        s_nxt.pre = '0;
                        s_nxt.ms  = '0;
                    end
                    else if (ms_tick)
                    begin
                        s_nxt.pre = '0;
                        s_nxt.ms  = ms_inc;
                        if (ms_inc >= win)
                        begin
                            s_nxt.state = ST_SLEEP;
                            s_nxt.ms    = '0;
                        end
                    end
                    else
                    begin
                        s_nxt.pre = PRE_W'(s_r.pre + 1'b1);
                    end
                end
                ST_CAL:
                begin
                    if (s_r.cal == CAL_W'(CAL_CYCLES - 1))
                    begin
                        s_nxt.state = ST_SLEEP;
                        s_nxt.cal   = '0;
                    end
                    else
                    begin
                        s_nxt.cal = CAL_W'(s_r.cal + 1'b1);
                    end
                end
                default:
                begin
                    s_nxt.state = ST_SLEEP;
                end
            endcase
        end
        s_nxt.tx_active   = (s_nxt.state == ST_TX);
        s_nxt.tx_data     = (s_nxt.state == ST_TX) & data_f;
        s_nxt.cal_busy    = (s_nxt.state == ST_CAL);
        s_nxt.sleep_state = (s_nxt.state == ST_SLEEP);
    end

    always_ff @(posedge core_clk or negedge rst_core_n)
    begin
        if (!rst_core_n)
        begin
            s_r <= CORE_RST_VAL;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign tx_active    = s_r.tx_active;
    assign tx_data      = s_r.tx_data;
    assign cal_busy     = s_r.cal_busy;
    assign sleep_state  = s_r.sleep_state;
    assign port_enabled = s_r.port_en;
    assign core_reset   = s_r.core_reset;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_core_n);

    crst_cal_a: assert property (crst_ev |=> (s_r.cal_busy && s_r.core_reset))
        else $error("core reset did not enter calibration");
    cal_len_a: assert property ($rose(s_r.cal_busy) |-> s_r.cal == '0)
        else $error("calibration did not start from zero");
    cal_sleep_a: assert property ($fell(s_r.cal_busy) |-> s_r.sleep_state)
        else $error("calibration end did not reach sleep");
    edge_mask_a: assert property ((s_r.sleep_state && pen_f && !crst_ev)
        |=> !s_r.tx_active)
        else $error("edge started transmission while port open");
    start_tx_a: assert property ((s_r.sleep_state && !pen_f && trig
        && !crst_ev) |=> s_r.tx_active)
        else $error("released port missed a start edge");
    hold_tx_a: assert property ((s_r.tx_active && data_f && !crst_ev)
        |=> (s_r.tx_active && s_r.ms == '0))
        else $error("high data did not hold transmission");
    win_bound_a: assert property (s_r.tx_active |-> s_r.ms < win)
        else $error("stop counter ran past the window");
    stop_time_a: assert property (($fell(s_r.tx_active) && !$past(crst_ev))
        |-> (MS_W'($past(s_r.ms) + 1'b1) >= $past(win)))
        else $error("transmission ended before the stop window");
    one_state_a: assert property ($onehot({s_r.tx_active, s_r.cal_busy,
        s_r.sleep_state}))
        else $error("status outputs not one-hot");

    tx_start_c: cover property ($rose(s_r.tx_active));
    tx_stop_c: cover property ($fell(s_r.tx_active) && !$past(crst_ev));
    cal_done_c: cover property ($fell(s_r.cal_busy));
    release_c: cover property ($fell(s_r.port_en));

endmodule

// ==== verif/twc_host_model.sv ====
`timescale 1ns/1ps
module twc_host_model
    import twc_pkg::*;
#(
    parameter int GAP_NS = 100
)
(
    // host-driven command port
    output logic port_clk,
    output logic port_data
);
    logic lclk;
    logic idle_lvl;

    // ------------------------------------------------------------
    // link clock, free inside the model, gated onto the pin
    // ------------------------------------------------------------
    initial
    begin
        lclk      = 1'b0;
        port_clk  = 1'b1;
        port_data = 1'b0;
        idle_lvl  = 1'b0;
        #1.7;
        forever #6 lclk = ~lclk;
    end

    // ------------------------------------------------------------
    // frames
    // ------------------------------------------------------------
    task automatic set_line(input logic v);
        @(negedge lclk);
        idle_lvl  = v;
        port_data = v;
    endtask

    // msb first; clock parked high outside frames
    task automatic send_bits(input logic [47:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            @(negedge lclk);
            port_clk  = 1'b1;
            port_data = v[i];
            @(posedge lclk);
            port_clk  = 1'b0;
        end
        @(negedge lclk);
        port_clk = 1'b1;
        @(negedge lclk);
        port_data = idle_lvl;
    endtask

    // no lead delay kept: data idles low in rising-edge mode
    task automatic port_reset();
        send_bits({32'h0000_0000, PORT_RST_CODE}, 48);
    endtask

    task automatic send_cmd(input logic [15:0] code);
        send_bits({32'h0000_0000, code}, 16);
        if (code === CORE_RST_CODE)
            #(GAP_NS);
    endtask
endmodule

// ==== verif/twc_cmd_ctrl_bench.sv ====
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            n_fail++; \
            $display("BAD %s expected %b seen %b", nm, exp, got); \
        end \
    end
module twc_cmd_ctrl_bench
    import twc_pkg::*;
;
    localparam int MS_C  = 20;
    localparam int CAL_C = 10;

    logic                  core_clk;
    logic                  rst_n;
    logic                  port_clk;
    logic                  port_data;
    logic                  trigger_edge_select;
    logic [STOP_SEL_W-1:0] stop_sel;
    logic                  tx_active;
    logic                  tx_data;
    logic                  cal_busy;
    logic                  sleep_state;
    logic                  port_enabled;
    logic                  core_reset;
    int                    n_fail;
    int                    n_checks;
    string                 nm [6] = '{"tx_active", "tx_data", "cal_busy",
                                      "sleep_state", "port_enabled", "core_reset"};

    twc_cmd_ctrl #(.MS_CYCLES(MS_C), .CAL_CYCLES(CAL_C)) i_twc_cmd_ctrl
    (
        .core_clk            (core_clk),
        .rst_n               (rst_n),
        .port_clk            (port_clk),
        .port_data           (port_data),
        .trigger_edge_select (trigger_edge_select),
        .stop_sel            (stop_sel),
        .tx_active           (tx_active),
        .tx_data             (tx_data),
        .cal_busy            (cal_busy),
        .sleep_state         (sleep_state),
        .port_enabled        (port_enabled),
        .core_reset          (core_reset)
    );

    twc_host_model #(.GAP_NS(MS_C * 5)) i_twc_host_model
    (
        .port_clk  (port_clk),
        .port_data (port_data)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    always #2.5 core_clk = ~core_clk;

    function automatic logic outv(input int s);
        case (s)
            0:       return tx_active;
            1:       return tx_data;
            2:       return cal_busy;
            3:       return sleep_state;
            4:       return port_enabled;
            default: return core_reset;
        endcase
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // bounded wait, then judge whatever is there
    task automatic wait_out(input int s, input logic v, input int n);
        int k;
        k = 0;
        while (outv(s) !== v && k < n)
        begin
            cyc(1);
            k++;
        end
        `CHK(nm[s], v, outv(s))
    endtask

    task automatic set_cfg(input logic edge_sel, input logic [3:0] sel);
        @(posedge core_clk);
        trigger_edge_select <= edge_sel;
        stop_sel            <= sel;
        cyc(2);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_rise_fine_stop();
        set_cfg(1'b1, 4'h0);
        i_twc_host_model.set_line(1'b1);
        wait_out(0, 1'b1, 12);
        wait_out(1, 1'b1, 4);
        i_twc_host_model.set_line(1'b0);
        cyc(2 * MS_C - 8);
        `CHK("tx_active", 1'b1, tx_active)
        wait_out(0, 1'b0, 20);
        `CHK("sleep_state", 1'b1, sleep_state)
    endtask

    task automatic t_port_cmds();
        i_twc_host_model.port_reset();
        wait_out(4, 1'b1, 12);
        i_twc_host_model.send_cmd(16'h1234);
        `CHK("port_enabled", 1'b1, port_enabled)
        fork
            i_twc_host_model.send_cmd(CORE_RST_CODE);
            wait_out(5, 1'b1, 200);
        join_any
        cyc(1);
        `CHK("core_reset", 1'b0, core_reset)
        `CHK("cal_busy", 1'b1, cal_busy)
        `CHK("sleep_state", 1'b0, sleep_state)
        wait_out(2, 1'b0, CAL_C + 2);
        `CHK("sleep_state", 1'b1, sleep_state)
        `CHK("port_enabled", 1'b1, port_enabled)
        wait fork;
        i_twc_host_model.set_line(1'b1);
        cyc(2 * MS_C);
        `CHK("tx_active", 1'b0, tx_active)
        i_twc_host_model.set_line(1'b0);
        cyc(6);
    endtask

    task automatic t_release_fall_coarse();
        i_twc_host_model.send_cmd(PORT_REL_CODE);
        wait_out(4, 1'b0, 12);
        `CHK("tx_active", 1'b0, tx_active)
        set_cfg(1'b0, 4'h8);
        i_twc_host_model.set_line(1'b1);
        cyc(10);
        `CHK("tx_active", 1'b0, tx_active)
        i_twc_host_model.set_line(1'b0);
        wait_out(0, 1'b1, 12);
        cyc(20 * MS_C - 20);
        `CHK("tx_active", 1'b1, tx_active)
        wait_out(0, 1'b0, 40);
    endtask

    // early shutdown: port reset and core reset right after payload
    task automatic t_core_reset_stops_tx();
        i_twc_host_model.set_line(1'b1);
        cyc(8);
        i_twc_host_model.set_line(1'b0);
        wait_out(0, 1'b1, 12);
        i_twc_host_model.port_reset();
        `CHK("tx_active", 1'b1, tx_active)
        i_twc_host_model.send_cmd(CORE_RST_CODE);
        `CHK("tx_active", 1'b0, tx_active)
        wait_out(3, 1'b1, CAL_C + 2);
        `CHK("port_enabled", 1'b1, port_enabled)
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        core_clk            = 1'b0;
        rst_n               = 1'b0;
        trigger_edge_select = 1'b1;
        stop_sel            = 4'h0;
        n_fail              = 0;
        n_checks            = 0;
        cyc(2);
        `CHK("sleep_state", 1'b1, sleep_state)
        `CHK("tx_active", 1'b0, tx_active)
        `CHK("port_enabled", 1'b0, port_enabled)
        @(posedge core_clk);
        rst_n <= 1'b1;
        cyc(8);
        t_rise_fine_stop();
        t_port_cmds();
        t_release_fall_coarse();
        t_core_reset_stops_tx();
        test_done();
    end

    // whole run needs well under 20 us
    initial
    begin
        #200us;
        n_fail++;
        test_done();
    end
endmodule
